// ### acs_top.sv
// Convert-start sequencing, address strap decode and open-drain pins.
`timescale 1ns/1ns
module acs_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [acs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [acs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [acs_pkg::DATA_W-1:0] reg_rdata,
    // Straps and pins
    input wire acs_pkg::acs_strap_s addr_strap_pin,
    input wire logic hs_version,
    input wire logic convert_start_pin,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic alert_busy_o,
    output logic alert_busy_oe_n,
    // Serial engine side
    input wire logic sda_pull_low,
    output logic [acs_pkg::BUS_ADDR_W-1:0] bus_address,
    output logic scl_level,
    output logic sda_level,
    output logic scl_rise,
    output logic scl_fall,
    // Converter core side
    input wire logic conv_done,
    input wire logic [acs_pkg::RES_W-1:0] conv_result,
    output logic core_power,
    output logic core_hold,
    output logic core_start
);

    // Pin synchronisers.
    logic [1:0] strap_m_q, strap_m_d;
    logic [1:0] strap_s_q, strap_s_d;
    logic ver_m_q, ver_m_d, ver_s_q, ver_s_d;
    logic cs_m_q, cs_m_d, cs_s_q, cs_s_d, cs_p_q, cs_p_d;
    logic scl_m_q, scl_m_d, scl_s_q, scl_s_d, scl_p_q, scl_p_d;
    logic sda_m_q, sda_m_d, sda_s_q, sda_s_d;

    always_comb begin
        strap_m_d = addr_strap_pin;
        strap_s_d = strap_m_q;
        ver_m_d = hs_version;
        ver_s_d = ver_m_q;
        cs_m_d = convert_start_pin;
        cs_s_d = cs_m_q;
        cs_p_d = cs_s_q;
        scl_m_d = scl_i;
        scl_s_d = scl_m_q;
        scl_p_d = scl_s_q;
        sda_m_d = sda_i;
        sda_s_d = sda_m_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strap_m_q <= 2'h0;
            strap_s_q <= 2'h0;
            ver_m_q <= 1'b0;
            ver_s_q <= 1'b0;
            cs_m_q <= 1'b0;
            cs_s_q <= 1'b0;
            cs_p_q <= 1'b0;
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            strap_m_q <= strap_m_d;
            strap_s_q <= strap_s_d;
            ver_m_q <= ver_m_d;
            ver_s_q <= ver_s_d;
            cs_m_q <= cs_m_d;
            cs_s_q <= cs_s_d;
            cs_p_q <= cs_p_d;
            scl_m_q <= scl_m_d;
            scl_s_q <= scl_s_d;
            scl_p_q <= scl_p_d;
            sda_m_q <= sda_m_d;
            sda_s_q <= sda_s_d;
        end
    end

    logic cs_rise, cs_fall;

    assign cs_rise = cs_s_q & ~cs_p_q;
    assign cs_fall = ~cs_s_q & cs_p_q;

    assign scl_level = scl_s_q;
    assign sda_level = sda_s_q;
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;

    // Address strap decode, loaded on each of the first three cycles after reset release, then held.
    logic [acs_pkg::BUS_ADDR_W-1:0] addr_q, addr_d;
    logic [1:0] strap_wait_q, strap_wait_d;
    logic [acs_pkg::BUS_ADDR_W-1:0] addr_sel;
    acs_pkg::acs_strap_s strap_now;

    always_comb begin
        strap_now = strap_s_q;
        if (strap_now.sense_low == strap_now.sense_high) begin
            addr_sel = acs_pkg::ADDR_FLOAT;
        end else if (ver_s_q) begin
            addr_sel = strap_now.sense_high ? acs_pkg::ADDR_HS_HIGH
                                            : acs_pkg::ADDR_HS_LOW;
        end else begin
            addr_sel = strap_now.sense_high ? acs_pkg::ADDR_STD_HIGH
                                            : acs_pkg::ADDR_STD_LOW;
        end
        addr_d = addr_q;
        strap_wait_d = strap_wait_q;
        if (strap_wait_q != 2'h3) begin
            strap_wait_d = strap_wait_q + 2'h1;
            addr_d = addr_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_q <= acs_pkg::ADDR_FLOAT;
            strap_wait_q <= 2'h0;
        end else begin
            addr_q <= addr_d;
            strap_wait_q <= strap_wait_d;
        end
    end

    assign bus_address = addr_q;

    // Conversion sequencer.
    acs_pkg::acs_state_e state_q, state_d;
    logic [acs_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic start_q, start_d;
    logic short_q, short_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        start_d = 1'b0;
        short_d = short_q;
        unique case (state_q)
            acs_pkg::ACS_SHUTDOWN: begin
                if (cs_rise) begin
                    state_d = acs_pkg::ACS_POWERUP;
                    cnt_d = acs_pkg::CNT_W'(acs_pkg::POWERUP_CYCLES - 1);
                end
            end
            acs_pkg::ACS_POWERUP: begin
                if (cs_fall) begin
                    state_d = acs_pkg::ACS_CONVERT;
                    start_d = 1'b1;
                    short_d = cnt_q != '0;
                end else if (cnt_q == '0) begin
                    state_d = acs_pkg::ACS_READY;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            acs_pkg::ACS_READY: begin
                if (cs_fall) begin
                    state_d = acs_pkg::ACS_CONVERT;
                    start_d = 1'b1;
                    short_d = 1'b0;
                end
            end
            acs_pkg::ACS_CONVERT: begin
                if (conv_done) begin
                    state_d = acs_pkg::ACS_SHUTDOWN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= acs_pkg::ACS_SHUTDOWN;
            cnt_q <= '0;
            start_q <= 1'b0;
            short_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
            short_q <= short_d;
        end
    end

    assign core_power = state_q != acs_pkg::ACS_SHUTDOWN;
    assign core_hold = state_q == acs_pkg::ACS_CONVERT;
    assign core_start = start_q;

    // Registers, result capture and the alert flag.
    acs_pkg::acs_cfg_s cfg_q, cfg_d;
    logic [acs_pkg::RES_W-1:0] upper_q, upper_d, lower_q, lower_d;
    logic [acs_pkg::RES_W-1:0] result_q, result_d;
    logic alert_q, alert_d, invalid_q, invalid_d;
    logic [acs_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic out_of_range, done_ok;

    assign done_ok = conv_done & (state_q == acs_pkg::ACS_CONVERT);
    assign out_of_range = (conv_result > upper_q) | (conv_result < lower_q);

    always_comb begin
        cfg_d = cfg_q;
        upper_d = upper_q;
        lower_d = lower_q;
        result_d = result_q;
        alert_d = alert_q;
        invalid_d = invalid_q;
        rdata_d = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                acs_pkg::CFG_OFFSET: begin
                    cfg_d.busy_sel = reg_wdata[acs_pkg::CFG_BUSY_SEL_BIT];
                    cfg_d.alert_en = reg_wdata[acs_pkg::CFG_ALERT_EN_BIT];
                end
                acs_pkg::UPPER_OFFSET: begin
                    upper_d = reg_wdata[acs_pkg::RES_W-1:0];
                end
                acs_pkg::LOWER_OFFSET: begin
                    lower_d = reg_wdata[acs_pkg::RES_W-1:0];
                end
                acs_pkg::STATUS_OFFSET: begin
                    if (reg_wdata[acs_pkg::STAT_ALERT_BIT]) begin
                        alert_d = 1'b0;
                    end
                    if (reg_wdata[acs_pkg::STAT_INVALID_BIT]) begin
                        invalid_d = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (done_ok) begin
            result_d = conv_result;
            invalid_d = short_q;
            if (cfg_q.alert_en && out_of_range) begin
                alert_d = 1'b1;
            end
        end
        if (reg_rd) begin
            unique case (reg_addr)
                acs_pkg::CFG_OFFSET: begin
                    rdata_d[acs_pkg::CFG_BUSY_SEL_BIT] = cfg_q.busy_sel;
                    rdata_d[acs_pkg::CFG_ALERT_EN_BIT] = cfg_q.alert_en;
                end
                acs_pkg::UPPER_OFFSET: begin
                    rdata_d[acs_pkg::RES_W-1:0] = upper_q;
                end
                acs_pkg::LOWER_OFFSET: begin
                    rdata_d[acs_pkg::RES_W-1:0] = lower_q;
                end
                acs_pkg::STATUS_OFFSET: begin
                    rdata_d[acs_pkg::STAT_ALERT_BIT] = alert_q;
                    rdata_d[acs_pkg::STAT_INVALID_BIT] = invalid_q;
                    rdata_d[acs_pkg::STAT_STATE_POS +: 2] = state_q;
                    rdata_d[acs_pkg::STAT_ADDR_POS +: acs_pkg::BUS_ADDR_W] =
                        addr_q;
                end
                acs_pkg::RESULT_OFFSET: begin
                    rdata_d[acs_pkg::RES_W-1:0] = result_q;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= '0;
            upper_q <= acs_pkg::UPPER_RESET;
            lower_q <= acs_pkg::LOWER_RESET;
            result_q <= '0;
            alert_q <= 1'b0;
            invalid_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            result_q <= result_d;
            alert_q <= alert_d;
            invalid_q <= invalid_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Open-drain pin drivers.
    logic ab_oe_n_q, ab_oe_n_d, sda_oe_n_q, sda_oe_n_d;

    always_comb begin
        if (cfg_q.busy_sel) begin
            ab_oe_n_d = state_d != acs_pkg::ACS_CONVERT;
        end else begin
            ab_oe_n_d = ~(alert_d & cfg_q.alert_en);
        end
        sda_oe_n_d = ~sda_pull_low;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ab_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            ab_oe_n_q <= ab_oe_n_d;
            sda_oe_n_q <= sda_oe_n_d;
        end
    end

    assign alert_busy_o = 1'b0;
    assign alert_busy_oe_n = ab_oe_n_q;
    assign sda_o = 1'b0;
    assign sda_oe_n = sda_oe_n_q;

endmodule

// ### acs_pkg.sv
// Constants and types for the convert-start block.
package acs_pkg;

    localparam int CLK_PERIOD_NS = 4;
    localparam int POWERUP_TIME_NS = 1000;
    localparam int POWERUP_CYCLES =
        (POWERUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 9;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 12;
    localparam int BUS_ADDR_W = 7;

    localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] UPPER_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] LOWER_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h0c;
    localparam logic [ADDR_W-1:0] RESULT_OFFSET = 8'h10;

    localparam int CFG_BUSY_SEL_BIT = 0;
    localparam int CFG_ALERT_EN_BIT = 1;
    localparam int STAT_ALERT_BIT = 0;
    localparam int STAT_INVALID_BIT = 1;
    localparam int STAT_STATE_POS = 4;
    localparam int STAT_ADDR_POS = 8;

    localparam logic [BUS_ADDR_W-1:0] ADDR_FLOAT = 7'h20;
    localparam logic [BUS_ADDR_W-1:0] ADDR_STD_LOW = 7'h21;
    localparam logic [BUS_ADDR_W-1:0] ADDR_STD_HIGH = 7'h22;
    localparam logic [BUS_ADDR_W-1:0] ADDR_HS_LOW = 7'h23;
    localparam logic [BUS_ADDR_W-1:0] ADDR_HS_HIGH = 7'h24;

    localparam logic [RES_W-1:0] UPPER_RESET = 12'hfff;
    localparam logic [RES_W-1:0] LOWER_RESET = 12'h000;

    typedef enum logic [1:0] {
        ACS_SHUTDOWN,
        ACS_POWERUP,
        ACS_READY,
        ACS_CONVERT
    } acs_state_e;

    typedef struct packed {
        logic alert_en;
        logic busy_sel;
    } acs_cfg_s;

    typedef struct packed {
        logic sense_low;
        logic sense_high;
    } acs_strap_s;

endpackage

// ### acs_host_model.sv
// Host model driving convert start and the serial clock.
`timescale 1ns/1ns
module acs_host_model (
    // Clock
    input wire logic clk,
    // Pins toward the block
    output logic cs,
    output logic scl
);
    initial scl = 1'b1;
    initial cs = 1'b0;
    task automatic set_cs(input logic v);
        @(posedge clk);
        cs <= v;
    endtask
    task automatic frame(input int n);
        repeat (n) begin
            #24 scl <= 1'b0;
            #24 scl <= 1'b1;
        end
    endtask
endmodule

// ### acs_top_monitor.sv
// Concurrent checks on the convert-start and strap block ports.
`timescale 1ns/1ns
module acs_top_monitor (
    // Clock and register writes
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // Pins and core
    input wire logic sda_pull_low,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic alert_busy_o,
    input wire logic alert_busy_oe_n,
    input wire logic [6:0] bus_address,
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    input wire logic core_power,
    input wire logic core_hold,
    input wire logic core_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic busy_q, alen_q;
    logic [11:0] up_q, lo_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            {alen_q, busy_q} <= 2'h0;
            up_q <= 12'hfff;
            lo_q <= 12'h000;
        end else if (reg_wr) begin
            if (reg_addr == 8'h00) {alen_q, busy_q} <= reg_wdata[1:0];
            if (reg_addr == 8'h04) up_q <= reg_wdata[11:0];
            if (reg_addr == 8'h08) lo_q <= reg_wdata[11:0];
        end
    end
    sequence s_end;
        conv_done && core_hold;
    endsequence
    sequence s_alert;
        conv_done && core_hold && alen_q && !busy_q &&
            (conv_result > up_q || conv_result < lo_q);
    endsequence
    a_sda_drain: assert property (sda_o == 1'b0)
        else $error("sda driven high");
    a_sda_pull: assert property (sda_pull_low |=> !sda_oe_n)
        else $error("sda not pulled");
    a_pin_drain: assert property (alert_busy_o == 1'b0)
        else $error("shared pin driven high");
    a_start_in_hold: assert property (
        core_start |-> core_hold && core_power)
        else $error("start outside hold");
    a_hold_starts: assert property ($rose(core_hold) |-> core_start)
        else $error("hold without start");
    a_idle_quiet: assert property (
        !core_power |-> !core_hold && !core_start)
        else $error("activity while off");
    a_end_shutdown: assert property (s_end |=> !core_power [*2])
        else $error("no shutdown after done");
    a_busy_pin: assert property (
        busy_q |-> alert_busy_oe_n == !core_hold)
        else $error("busy pin wrong");
    a_pin_release: assert property (
        !busy_q && !alen_q |=> alert_busy_oe_n)
        else $error("shared pin not released");
    a_alert_set: assert property (s_alert |=> !alert_busy_oe_n)
        else $error("alert not raised");
    a_addr_legal: assert property (bus_address inside {[7'h20:7'h24]})
        else $error("illegal bus address");
endmodule

// ### tb.sv
// Self-checking bench for the convert-start and strap block.
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rdv, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, hs = 1'b0, pull = 1'b0;
    logic done = 1'b0, cs, scl, sda_o, sda_oe_n, ab_o, ab_n, scl_rise;
    logic scl_lv, sda_lv, scl_fall;
    logic [1:0] strap = 2'b10;
    logic [11:0] res = 12'h000;
    logic [6:0] bus_address;
    logic core_power, core_hold, core_start;
    int num_errors = 0, checked = 0, nrise = 0, nfall = 0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (scl_rise === 1'b1) nrise++;
        if (scl_fall === 1'b1) nfall++;
    end
    acs_host_model acs_host_model_inst (.clk, .cs, .scl);
    acs_top acs_top_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .addr_strap_pin(strap), .hs_version(hs),
        .convert_start_pin(cs), .scl_i(scl), .sda_i(sda_oe_n | sda_o),
        .sda_o, .sda_oe_n, .alert_busy_o(ab_o), .alert_busy_oe_n(ab_n),
        .sda_pull_low(pull), .bus_address, .scl_level(scl_lv),
        .sda_level(sda_lv), .scl_rise, .scl_fall, .conv_done(done),
        .conv_result(res),
        .core_power, .core_hold, .core_start);
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t %s got %h", $time, m, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic rst_with(input logic [1:0] s, input logic h);
        @(posedge clk);
        rst <= 1'b1;
        strap <= s;
        hs <= h;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic wait_start();
        int n;
        n = 0;
        while (core_start !== 1'b1) begin
            @(posedge clk);
            #1 n++;
            if (n > 20) begin
                num_errors++;
                $display("mismatch t=%0t no start", $time);
                close_out();
            end
        end
    endtask
    task automatic finish_conv(input logic [11:0] r);
        @(posedge clk);
        done <= 1'b1;
        res <= r;
        @(posedge clk);
        done <= 1'b0;
        #1;
    endtask
    task automatic convert(input int hi, input logic [11:0] r);
        acs_host_model_inst.set_cs(1'b1);
        repeat (hi) @(posedge clk);
        acs_host_model_inst.set_cs(1'b0);
        wait_start();
        finish_conv(r);
    endtask
    task automatic t_regs();
        rd(8'h00);
        chk(rdv, 32'h0, "cfg");
        rd(8'h04);
        chk(rdv, 32'hfff, "upper");
        rd(8'h14);
        chk(rdv, 32'h0, "unmapped");
        rd(8'h0c);
        chk(rdv[5:4], 2'h0, "shutdown");
        $display("regs done");
    endtask
    task automatic t_strap();
        logic [1:0] s_l [6] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h3};
        logic h_l [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic [6:0] a_l [6] = '{7'h21, 7'h22, 7'h23, 7'h24, 7'h20, 7'h20};
        for (int i = 0; i < 6; i++) begin
            rst_with(s_l[i], h_l[i]);
            chk(bus_address, a_l[i], "strap");
        end
        $display("strap done");
    endtask
    task automatic t_busy();
        wr(8'h00, 32'h1);
        acs_host_model_inst.set_cs(1'b1);
        repeat (240) @(posedge clk);
        rd(8'h0c);
        chk({core_power, rdv[5:4]}, 3'h5, "powering");
        repeat (20) @(posedge clk);
        rd(8'h0c);
        chk({core_hold, rdv[5:4]}, 3'h2, "ready");
        acs_host_model_inst.set_cs(1'b0);
        wait_start();
        chk({core_hold, ab_n}, 2'h2, "busy on");
        finish_conv(12'h5a5);
        chk({core_power, ab_n}, 2'h1, "off");
        rd(8'h10);
        chk(rdv, 32'h5a5, "result");
        convert(50, 12'h123);
        rd(8'h0c);
        chk(rdv[1], 1'b1, "short pulse");
        $display("busy done");
    endtask
    task automatic t_alert();
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h800);
        wr(8'h08, 32'h100);
        convert(260, 12'h900);
        chk(ab_n, 1'b0, "above");
        wr(8'h0c, 32'h1);
        repeat (2) @(posedge clk);
        chk(ab_n, 1'b1, "cleared");
        convert(260, 12'h0ff);
        chk(ab_n, 1'b0, "below");
        wr(8'h0c, 32'h1);
        convert(260, 12'h400);
        chk(ab_n, 1'b1, "in range");
        $display("alert done");
    endtask
    task automatic t_wire();
        @(posedge clk);
        pull <= 1'b1;
        repeat (4) @(posedge clk);
        pull <= 1'b0;
        #1 chk({sda_o, sda_oe_n, sda_lv}, 3'h0, "sda low");
        nrise = 0;
        nfall = 0;
        acs_host_model_inst.frame(9);
        repeat (6) @(posedge clk);
        chk(nrise, 9, "scl rises");
        chk(nfall, 9, "scl falls");
        chk({scl_lv, sda_oe_n, sda_lv}, 3'h7, "lines free");
        $display("wire done");
    endtask
    initial begin
        rst_with(2'b10, 1'b0);
        t_regs();
        t_strap();
        t_busy();
        t_alert();
        t_wire();
        close_out();
    end
endmodule
bind acs_top acs_top_monitor acs_top_monitor_inst (.clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .sda_pull_low, .sda_o, .sda_oe_n, .alert_busy_o,
    .alert_busy_oe_n, .bus_address, .conv_done, .conv_result, .core_power,
    .core_hold, .core_start);
